//--- hash_result_auto_compare.sv
// Digest auto-check: compares the hash result with an expected digest.
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "hash_check_cfg.svh"
module hash_result_auto_compare (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Hash core side
   input wire logic [255:0] digest,
   input wire logic digest_valid,
   input wire logic msg_end,
   output logic [31:0] in_word,
   output logic in_word_valid,
   output logic hmac_select,
   output logic double_buffer_enable,
   // Interrupt
   output logic irq
);

   // ****************************************************************
   // Bus slave
   // ****************************************************************
   logic ap_valid_r, ap_valid_nxt;
   logic ap_write_r, ap_write_nxt;
   logic [7:0] ap_addr_r, ap_addr_nxt;
   logic rd_wait_r, rd_wait_nxt;
   logic [31:0] hrdata_r, hrdata_nxt;
   logic take, wr, rd_first;
   logic [31:0] rd_mux;

   // ****************************************************************
   // Registers and check state
   // ****************************************************************
   hash_check_pkg::src_t src_r, src_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic hmac_r, hmac_nxt;
   logic dbuf_r, dbuf_nxt;
   logic [2:0] mask_r, mask_nxt;
   logic [2:0] stat_r, stat_nxt;
   hash_check_pkg::result_t res_r, res_nxt;
   logic [2:0] sptr_r, sptr_nxt;
   logic [3:0] cap_cnt_r, cap_cnt_nxt;
   logic armed_r, armed_nxt;
   logic pend_r, pend_nxt;
   hash_check_pkg::cmp_state_t st_r, st_nxt;
   logic [2:0] idx_r, idx_nxt;
   logic fail_r, fail_nxt;
   logic [255:0] digest_r, digest_nxt;
   logic [31:0] in_word_r, in_word_nxt;
   logic in_word_valid_r, in_word_valid_nxt;
   logic irq_r, irq_nxt;
   logic [3:0] cnt_eff;
   logic store_we, cap_we, last_word, start;
   logic [2:0] set_bits, clr_bits;
   logic [31:0] store_rd, cap_rd, exp_word, dig_word;

   assign take = hsel && htrans[1] && hready;
   assign wr = ap_valid_r && ap_write_r;
   assign rd_first = ap_valid_r && !ap_write_r && !rd_wait_r;
   assign hreadyout = !rd_first;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   // Reads take one wait state so that read data always come from a flop.
   always_comb begin
      ap_valid_nxt = ap_valid_r;
      ap_write_nxt = ap_write_r;
      ap_addr_nxt = ap_addr_r;
      rd_wait_nxt = rd_first;
      hrdata_nxt = hrdata_r;
      if (hreadyout) begin
         ap_valid_nxt = take;
         ap_write_nxt = hwrite;
         ap_addr_nxt = haddr[7:0];
      end
      if (rd_first) begin
         hrdata_nxt = rd_mux;
      end
   end

   // Unmapped offsets and the store data port read as zero.
   always_comb begin
      unique case (ap_addr_r)
         `OFS_MODE: rd_mux = {15'h0000, dbuf_r, 7'h00, hmac_r, cnt_r,
                              2'b00, src_r};
         `OFS_IRQ_MASK: rd_mux = {29'h0000_0000, mask_r};
         `OFS_IRQ_STAT: rd_mux = {22'h00_0000, res_r, 5'h00, stat_r};
         `OFS_STORE_PTR: rd_mux = {29'h0000_0000, sptr_r};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // ****************************************************************
   // Software registers and status
   // ****************************************************************
   assign cnt_eff = (cnt_r == 4'h0 || cnt_r > `DIGEST_WORDS) ?
                    `DIGEST_WORDS : cnt_r;
   assign store_we = wr && ap_addr_r == `OFS_STORE_DATA;
   assign cap_we = wr && ap_addr_r == `OFS_INPUT_WORDS && armed_r &&
                   src_r == hash_check_pkg::SRC_INPUT;

   always_comb begin
      src_nxt = src_r;
      cnt_nxt = cnt_r;
      hmac_nxt = hmac_r;
      dbuf_nxt = dbuf_r;
      mask_nxt = mask_r;
      sptr_nxt = sptr_r;
      clr_bits = 3'h0;
      if (wr && ap_addr_r == `OFS_MODE) begin
         src_nxt = hash_check_pkg::src_t'(hwdata[`MODE_SRC_LSB +: 2]);
         cnt_nxt = hwdata[`MODE_CNT_LSB +: 4];
         hmac_nxt = hwdata[`MODE_HMAC_BIT];
         dbuf_nxt = hwdata[`MODE_DBUF_BIT];
      end
      if (wr && ap_addr_r == `OFS_IRQ_MASK) begin
         mask_nxt = hwdata[2:0];
      end
      if (wr && ap_addr_r == `OFS_IRQ_STAT) begin
         clr_bits = hwdata[2:0];
      end
      if (wr && ap_addr_r == `OFS_STORE_PTR) begin
         sptr_nxt = hwdata[2:0];
      end else if (store_we) begin
         sptr_nxt = sptr_r + 3'h1;
      end
      // A hardware set in the clearing cycle wins.
      stat_nxt = (stat_r & ~clr_bits) | set_bits;
      irq_nxt = |(stat_nxt & mask_nxt);
   end

   // ****************************************************************
   // Expected digest capture and message forwarding
   // ****************************************************************
   always_comb begin
      cap_cnt_nxt = cap_cnt_r;
      armed_nxt = armed_r;
      in_word_nxt = in_word_r;
      in_word_valid_nxt = 1'b0;
      digest_nxt = digest_valid ? digest : digest_r;
      if (msg_end) begin
         armed_nxt = 1'b1;
         cap_cnt_nxt = 4'h0;
      end else if (cap_we) begin
         cap_cnt_nxt = cap_cnt_r + 4'h1;
         armed_nxt = (cap_cnt_r + 4'h1) != cnt_eff;
      end
      if (wr && ap_addr_r == `OFS_INPUT_WORDS && !cap_we) begin
         in_word_nxt = hwdata;
         in_word_valid_nxt = 1'b1;
      end
   end

   // ****************************************************************
   // Comparison sequencer
   // ****************************************************************
   assign last_word = {1'b0, idx_r} == cnt_eff - 4'h1;
   assign start = st_r == hash_check_pkg::ST_IDLE && pend_r &&
                  (src_r == hash_check_pkg::SRC_STORE ||
                   (src_r == hash_check_pkg::SRC_INPUT && !armed_r &&
                    cap_cnt_r == cnt_eff));
   assign exp_word = (src_r == hash_check_pkg::SRC_STORE) ?
                     store_rd : cap_rd;
   assign dig_word = digest_r[{idx_r, 5'h00} +: 32];

   always_comb begin
      st_nxt = st_r;
      idx_nxt = idx_r;
      fail_nxt = fail_r;
      res_nxt = res_r;
      pend_nxt = pend_r;
      set_bits = 3'h0;
      if (digest_valid) begin
         set_bits[`STAT_READY_BIT] = 1'b1;
      end
      unique case (st_r)
         hash_check_pkg::ST_IDLE: begin
            if (start) begin
               st_nxt = hash_check_pkg::ST_READ;
               idx_nxt = 3'h0;
               fail_nxt = 1'b0;
               pend_nxt = 1'b0;
            end
         end
         hash_check_pkg::ST_READ: begin
            st_nxt = hash_check_pkg::ST_CHECK;
         end
         hash_check_pkg::ST_CHECK: begin
            if (exp_word != dig_word) begin
               fail_nxt = 1'b1;
            end
            if (last_word) begin
               st_nxt = hash_check_pkg::ST_DONE;
            end else begin
               idx_nxt = idx_r + 3'h1;
               st_nxt = hash_check_pkg::ST_READ;
            end
         end
         hash_check_pkg::ST_DONE: begin
            st_nxt = hash_check_pkg::ST_IDLE;
            set_bits[`STAT_DONE_BIT] = 1'b1;
            set_bits[`STAT_FAIL_BIT] = fail_r;
            res_nxt = fail_r ? hash_check_pkg::RES_FAIL :
                      hash_check_pkg::RES_PASS;
         end
      endcase
      if (digest_valid && (src_r == hash_check_pkg::SRC_STORE ||
                           src_r == hash_check_pkg::SRC_INPUT)) begin
         pend_nxt = 1'b1;
      end
   end

   word_store u_internal_store (
      .mclk(mclk),
      .nrst(nrst),
      .we(store_we),
      .waddr(sptr_r),
      .wdata(hwdata),
      .raddr(idx_r),
      .rdata_r(store_rd)
   );

   word_store u_expected_capture (
      .mclk(mclk),
      .nrst(nrst),
      .we(cap_we),
      .waddr(cap_cnt_r[2:0]),
      .wdata(hwdata),
      .raddr(idx_r),
      .rdata_r(cap_rd)
   );

   assign in_word = in_word_r;
   assign in_word_valid = in_word_valid_r;
   assign hmac_select = hmac_r;
   assign double_buffer_enable = dbuf_r;
   assign irq = irq_r;

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ap_valid_r <= 1'b0;
         ap_write_r <= 1'b0;
         ap_addr_r <= 8'h00;
         rd_wait_r <= 1'b0;
         hrdata_r <= 32'h0000_0000;
         src_r <= hash_check_pkg::SRC_OFF;
         cnt_r <= 4'h0;
         hmac_r <= 1'b0;
         dbuf_r <= 1'b0;
         mask_r <= `MASK_RESET;
         stat_r <= 3'h0;
         res_r <= hash_check_pkg::RES_NONE;
         sptr_r <= 3'h0;
         cap_cnt_r <= 4'h0;
         armed_r <= 1'b0;
         pend_r <= 1'b0;
         st_r <= hash_check_pkg::ST_IDLE;
         idx_r <= 3'h0;
         fail_r <= 1'b0;
         digest_r <= 256'h0;
         in_word_r <= 32'h0000_0000;
         in_word_valid_r <= 1'b0;
         irq_r <= 1'b0;
      end else begin
         ap_valid_r <= ap_valid_nxt;
         ap_write_r <= ap_write_nxt;
         ap_addr_r <= ap_addr_nxt;
         rd_wait_r <= rd_wait_nxt;
         hrdata_r <= hrdata_nxt;
         src_r <= src_nxt;
         cnt_r <= cnt_nxt;
         hmac_r <= hmac_nxt;
         dbuf_r <= dbuf_nxt;
         mask_r <= mask_nxt;
         stat_r <= stat_nxt;
         res_r <= res_nxt;
         sptr_r <= sptr_nxt;
         cap_cnt_r <= cap_cnt_nxt;
         armed_r <= armed_nxt;
         pend_r <= pend_nxt;
         st_r <= st_nxt;
         idx_r <= idx_nxt;
         fail_r <= fail_nxt;
         digest_r <= digest_nxt;
         in_word_r <= in_word_nxt;
         in_word_valid_r <= in_word_valid_nxt;
         irq_r <= irq_nxt;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   logic [3:0] checked_r;
   always_ff @(posedge mclk) begin
      if (!nrst || st_r == hash_check_pkg::ST_IDLE) begin
         checked_r <= 4'h0;
      end else if (st_r == hash_check_pkg::ST_CHECK) begin
         checked_r <= checked_r + 4'h1;
      end
   end

   sequence quiet_start;
      st_r != hash_check_pkg::ST_DONE [*3];
   endsequence
   sequence reach_done;
      ##[1:17] st_r == hash_check_pkg::ST_DONE;
   endsequence

   chk_fail_irq: assert property (
      stat_r[`STAT_FAIL_BIT] && mask_r[`STAT_FAIL_BIT] && !wr |=> irq)
      else $error("Unmasked failure did not raise the interrupt.");
   chk_store_source: assert property (
      st_r == hash_check_pkg::ST_CHECK && src_r == hash_check_pkg::SRC_STORE
      |-> exp_word == u_internal_store.mem[idx_r])
      else $error("Store source did not use the internal store.");
   chk_store_hidden: assert property (
      rd_first && ap_addr_r == `OFS_STORE_DATA |=> hrdata == 32'h0)
      else $error("Internal store data leaked to the bus.");
   chk_input_capture: assert property (
      cap_we && !msg_end |=> cap_cnt_r == $past(cap_cnt_r) + 4'h1)
      else $error("Expected word after message was not captured.");
   chk_word_count: assert property (
      st_r == hash_check_pkg::ST_DONE |-> checked_r == cnt_eff)
      else $error("Compared word count differs from programmed count.");
   chk_result_field: assert property (
      st_r == hash_check_pkg::ST_DONE |=> stat_r[`STAT_DONE_BIT] &&
      res_r == ($past(fail_r) ? hash_check_pkg::RES_FAIL :
                hash_check_pkg::RES_PASS))
      else $error("Result state not updated with the done flag.");
   chk_done_irq: assert property (
      st_r == hash_check_pkg::ST_DONE && mask_r[`STAT_DONE_BIT] && !wr
      |=> irq)
      else $error("Enabled completion did not raise the interrupt.");
   chk_done_later: assert property (
      digest_valid && !pend_r && st_r == hash_check_pkg::ST_IDLE &&
      src_r == hash_check_pkg::SRC_STORE && !wr |-> quiet_start ##0
      reach_done)
      else $error("Check completion not several cycles after ready.");

endmodule

//--- hash_check_cfg.svh
// Offsets, field positions, reset values and the digest word count of the check block.
//
// Functional notes
// - Compare computed digest with expected one; a failure may raise an interrupt.
// - Source selector 1 takes the expected digest from the internal store.
// - The internal store can never be read back by software.
// - Selector 2 captures expected digest from input words after the message.
// - Only the programmed number of 32-bit words is compared; a count of 0 or above 8 compares all 8.
// - The outcome shows in a result-state field of the status register.
// - Completion of the comparison raises an interrupt when enabled.
// - Done flag and interrupt come several cycles after the result-ready flag.
`ifndef HASH_CHECK_CFG_SVH
`define HASH_CHECK_CFG_SVH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define OFS_MODE 8'h00
`define OFS_IRQ_MASK 8'h04
`define OFS_IRQ_STAT 8'h08
`define OFS_STORE_DATA 8'h0c
`define OFS_STORE_PTR 8'h10
`define OFS_INPUT_WORDS 8'h14

// ****************************************************************
// Field positions
// ****************************************************************
`define MODE_SRC_LSB 0
`define MODE_CNT_LSB 4
`define MODE_HMAC_BIT 8
`define MODE_DBUF_BIT 16
`define STAT_READY_BIT 0
`define STAT_DONE_BIT 1
`define STAT_FAIL_BIT 2
`define STAT_RES_LSB 8

// ****************************************************************
// Reset values and counts
// ****************************************************************
`define MODE_RESET 32'h0000_0000
`define MASK_RESET 3'h0
`define DIGEST_WORDS 4'h8

`endif

//--- hash_check_pkg.sv
// Types shared by the digest check block.
package hash_check_pkg;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READ = 2'b01,
      ST_CHECK = 2'b10,
      ST_DONE = 2'b11
   } cmp_state_t;

   typedef enum logic [1:0] {
      SRC_OFF = 2'b00,
      SRC_STORE = 2'b01,
      SRC_INPUT = 2'b10,
      SRC_RSVD = 2'b11
   } src_t;

   typedef enum logic [1:0] {
      RES_NONE = 2'b00,
      RES_PASS = 2'b01,
      RES_FAIL = 2'b10,
      RES_RSVD = 2'b11
   } result_t;

endpackage

//--- word_store.sv
// Eight-word store with one write port and a registered read port.
`timescale 1ns/1ps
module word_store (
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Write port
   input wire logic we,
   input wire logic [2:0] waddr,
   input wire logic [31:0] wdata,
   // Read port
   input wire logic [2:0] raddr,
   output logic [31:0] rdata_r
);

   logic [31:0] mem [0:7];
   logic [31:0] rdata_nxt;

   always_comb begin
      rdata_nxt = mem[raddr];
   end

   always_ff @(posedge mclk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         rdata_r <= 32'h0000_0000;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end

endmodule

//--- hash_result_auto_compare_tb.sv
// Self-checking testbench of the digest auto-check block.
`timescale 1ns/1ps
module hash_result_auto_compare_tb;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [255:0] digest = 256'h0;
   logic digest_valid = 1'b0;
   logic msg_end = 1'b0;
   logic [31:0] in_word;
   logic in_word_valid;
   logic hmac_select;
   logic double_buffer_enable;
   logic irq;
   logic rd_ph = 1'b0;
   logic [31:0] rd_q[$];
   logic [31:0] fw_q[$];
   int error_cnt = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   logic [3:0] cnt;
   logic [31:0] ew;

   assign hready = hreadyout;

   always #2.5 mclk = ~mclk;

   hash_result_auto_compare dut_u (
      .mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .digest(digest), .digest_valid(digest_valid),
      .msg_end(msg_end), .in_word(in_word), .in_word_valid(in_word_valid),
      .hmac_select(hmac_select),
      .double_buffer_enable(double_buffer_enable), .irq(irq)
   );

   // ****************************************************************
   // Checking and closing
   // ****************************************************************
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected word at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected flag at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask

   task automatic finish_test();
      $display("errors %0d, compares %0d", error_cnt, compares);
      if (error_cnt == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // The monitor pairs every read completion and forwarded word with a note.
   always @(posedge mclk) begin
      if (rd_ph && hreadyout === 1'b1) begin
         chk_bit(hresp, 1'b0);
         if (rd_q.size() == 0) begin
            chk_word(hrdata, 32'hffff_ffff);
         end else begin
            chk_word(hrdata, rd_q.pop_front());
         end
      end
      if (hreadyout === 1'b1) begin
         rd_ph <= hsel & htrans[1] & ~hwrite;
      end
      if (in_word_valid === 1'b1) begin
         if (fw_q.size() == 0) begin
            chk_word(in_word, 32'hffff_ffff);
         end else begin
            chk_word(in_word, fw_q.pop_front());
         end
      end
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         finish_test();
      end
   end

   // ****************************************************************
   // Bus and core stimulus
   // ****************************************************************
   task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge mclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge mclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wr ? d : 32'h0;
      do @(posedge mclk); while (hreadyout !== 1'b1);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      rd_q.push_back(exp);
      bus(1'b0, a, 32'h0);
   endtask

   task automatic pulse_digest();
      @(posedge mclk);
      digest_valid <= 1'b1;
      @(posedge mclk);
      digest_valid <= 1'b0;
   endtask

   task automatic wait_irq(output int k);
      k = 0;
      while (irq !== 1'b1 && k < 200) begin
         @(posedge mclk);
         k++;
      end
   endtask

   // One auto-check run; mask selects the done or the fail source.
   task automatic run_check(input logic fail);
      bus(1'b1, 8'h04, fail ? 32'h4 : 32'h2);
      pulse_digest();
      wait_irq(n);
      chk_bit(irq, 1'b1);
      chk_bit(n > 2, 1'b1);
      rd(8'h08, fail ? 32'h0000_0207 : 32'h0000_0103);
      bus(1'b1, 8'h08, 32'h7);
      rd(8'h08, fail ? 32'h0000_0200 : 32'h0000_0100);
      chk_bit(irq, 1'b0);
   endtask

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      void'($urandom(42544));
      repeat (2) @(posedge mclk);
      nrst <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         digest[32*i +: 32] <= $urandom();
      end
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h0);
      rd(8'h08, 32'h0);
      rd(8'h20, 32'h0);
      chk_bit(irq, 1'b0);
      bus(1'b1, 8'h00, 32'h0001_0100);
      rd(8'h00, 32'h0001_0100);
      chk_bit(hmac_select, 1'b1);
      chk_bit(double_buffer_enable, 1'b1);
      bus(1'b1, 8'h00, 32'h0);
      pulse_digest();
      repeat (30) @(posedge mclk);
      rd(8'h08, 32'h0000_0001);
      // The reserved source code must not start a comparison either.
      bus(1'b1, 8'h00, 32'h3);
      pulse_digest();
      repeat (30) @(posedge mclk);
      rd(8'h08, 32'h0000_0001);
      bus(1'b1, 8'h08, 32'h7);
      // Internal store runs: word count, flipped word, expected failure.
      for (int c = 0; c < 4; c++) begin
         cnt = (c == 0) ? 4'h0 : (c == 3) ? 4'h8 : 4'h3;
         bus(1'b1, 8'h10, 32'h0);
         for (int k = 0; k < 8; k++) begin
            ew = digest[32*k +: 32];
            if ((c == 1 && k == 3) || (c == 2 && k == 2) ||
               (c == 3 && k == 7)) begin
               ew = ~ew;
            end
            bus(1'b1, 8'h0c, ew);
            rd(8'h0c, 32'h0);
         end
         bus(1'b1, 8'h00, {24'h0, cnt, 4'h1});
         run_check(c >= 2);
      end
      // Expected digest taken from input words after the message.
      for (int f = 0; f < 2; f++) begin
         bus(1'b1, 8'h00, 32'h0000_0022);
         ew = $urandom();
         fw_q.push_back(ew);
         bus(1'b1, 8'h14, ew);
         @(posedge mclk);
         msg_end <= 1'b1;
         @(posedge mclk);
         msg_end <= 1'b0;
         bus(1'b1, 8'h14, digest[31:0]);
         bus(1'b1, 8'h14, digest[63:32] ^ {31'h0, f[0]});
         run_check(f[0]);
      end
      repeat (5) @(posedge mclk);
      finish_test();
   end
endmodule
